// *** rtl/dbm_pkg.sv ***
/*
  Shared constants and bus carriers for the dual crossbar fabric and its bridges.
  Assumes one clock for the whole fabric; the low-power side advances on a divided tick.
*/
package dbm_pkg;

  // data path and id widths
  localparam int DATA_W  = 32;
  localparam int SID_W   = 4;
  localparam int MID_W   = 2;
  localparam int NUM_MST = 3;
  localparam int NUM_SLV = 10;
  localparam int NUM_XB  = 2;
  localparam int LVL_W   = 2;
  localparam int DIV_W   = 8;

  // crossbar index
  localparam int XB_HS = 0;
  localparam int XB_LP = 1;

  // high-speed crossbar master and slave ids
  localparam int HS_MID_CORE   = 0;
  localparam int HS_MID_DEBUG  = 1;
  localparam int HS_MID_UPWARD = 2;
  localparam int HS_SID_FLASH      = 0;
  localparam int HS_SID_SRAM_CORE  = 1;
  localparam int HS_SID_SRAM_DEBUG = 2;
  localparam int HS_SID_PERIPH_B   = 3;
  localparam int HS_SID_DOWNWARD   = 4;
  localparam int HS_EXT_SLV        = 4;

  // low-power crossbar master and slave ids
  localparam int LP_MID_DOWNWARD = 0;
  localparam int LP_MID_DMA      = 2;
  localparam int LP_SID_PERIPH_A = 0;
  localparam int LP_SID_PERIPH_C = 1;
  localparam int LP_SID_PERIPH_D = 2;
  localparam int LP_SID_PERIPH_E = 3;
  localparam int LP_SID_LP_SRAM2 = 5;
  localparam int LP_SID_LP_SRAM1 = 7;
  localparam int LP_SID_UPWARD   = 8;
  localparam int LP_SID_HS_SRAM2 = 9;

  // one bit per populated slave id
  localparam logic [15:0] HS_SLV_MAP = 16'h001f;
  localparam logic [15:0] LP_SLV_MAP = 16'h03af;

  // register map, byte addresses on the register bus
  localparam logic [31:0] ULL_CTRL_ADDR = 32'h4100_8120;
  localparam logic [31:0] LP_DIV_ADDR   = 32'h4100_8124;
  localparam logic [31:0] STATUS_ADDR   = 32'h4100_8128;
  localparam logic [31:0] ULL_ENABLE    = 32'h0000_0001;
  localparam logic [DIV_W-1:0] LP_DIV_RST = 8'h00;
  localparam logic        ULL_RST       = 1'b0;
  localparam int STAT_DOWN_LSB = 0;
  localparam int STAT_UP_LSB   = 4;
  localparam int STAT_ULL_BIT  = 8;

  // bridge sizing and intrinsic stalls
  localparam int DOWN_FIFO_DEPTH = 3;
  localparam int UP_FIFO_DEPTH   = 1;
  localparam logic [1:0] WR_FULL_STALL = 2'h1;
  localparam logic [1:0] RD_STALL      = 2'h2;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [SID_W-1:0]  slave;
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
  } dbm_req_t;

  typedef struct packed {
    logic              done;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } dbm_rsp_t;

endpackage

// *** rtl/dbm_bridge.sv ***
/*
  Crossbar-to-crossbar bridge with a posted-write buffer and stalled reads.
  Assumes requests hold until a one-cycle done, and lp_tick marks low-power clock edges.
*/
module dbm_bridge #(
  parameter int FIFO_DEPTH   = 3,
  parameter bit LP_ON_MASTER = 1'b1
) (
  input  logic                          clk,
  input  logic                          sys_rst,
  input  logic                          ull,
  input  logic                          lp_tick,
  input  dbm_pkg::dbm_req_t             s_req,
  output dbm_pkg::dbm_rsp_t             s_rsp,
  output dbm_pkg::dbm_req_t             m_req,
  input  dbm_pkg::dbm_rsp_t             m_rsp,
  output logic [dbm_pkg::LVL_W-1:0]     level
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WSTALL, ST_RSTALL, ST_RISSUE, ST_RWAIT, ST_RESP
  } dbm_brg_st_t;

  dbm_brg_st_t                state_ff;
  logic [1:0]                 stall_ff;
  dbm_pkg::dbm_req_t          fifo_ff [FIFO_DEPTH];
  logic [PTR_W-1:0]           wptr_ff;
  logic [PTR_W-1:0]           rptr_ff;
  logic [dbm_pkg::LVL_W-1:0]  cnt_ff;
  dbm_pkg::dbm_rsp_t          s_rsp_ff;
  dbm_pkg::dbm_rsp_t          hold_ff;
  dbm_pkg::dbm_req_t          m_req_ff;
  logic                       tick_s;
  logic                       tick_m;
  logic                       full;
  logic                       take;
  logic                       push;
  logic                       pop;

  // only the low-power side waits for its divided clock edge
  assign tick_m = LP_ON_MASTER ? lp_tick : 1'b1;
  assign tick_s = LP_ON_MASTER ? 1'b1 : lp_tick;
  assign full   = (cnt_ff == dbm_pkg::LVL_W'(FIFO_DEPTH));
  // a request still high while our done shows is the one just finished
  assign take   = s_req.valid && !s_rsp_ff.done && tick_s && (state_ff == ST_IDLE);
  assign push   = take && s_req.write && !full;
  assign pop    = m_req_ff.valid && m_req_ff.write && m_rsp.done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end else begin
      if (push) begin
        fifo_ff[wptr_ff] <= s_req;
        wptr_ff <= (wptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + dbm_pkg::LVL_W'(push) - dbm_pkg::LVL_W'(pop);
    end
  end

  // slave-side sequencing: stalls, read forwarding, answers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      stall_ff <= '0;
      s_rsp_ff <= '0;
      hold_ff  <= '0;
    end else begin
      s_rsp_ff <= '0;
      case (state_ff)
        ST_IDLE: begin
          if (push) begin
            s_rsp_ff.done <= 1'b1;
          end else if (take && s_req.write && !ull) begin
            state_ff <= ST_WSTALL;
            stall_ff <= dbm_pkg::WR_FULL_STALL;
          end else if (take && !s_req.write) begin
            state_ff <= ull ? ST_RISSUE : ST_RSTALL;
            stall_ff <= dbm_pkg::RD_STALL;
          end
        end
        ST_WSTALL: begin
          if (stall_ff == 2'h1) state_ff <= ST_IDLE;
          stall_ff <= stall_ff - 2'h1;
        end
        ST_RSTALL: begin
          if (stall_ff == 2'h1) state_ff <= ST_RISSUE;
          stall_ff <= stall_ff - 2'h1;
        end
        ST_RISSUE: begin
          if (m_req_ff.valid && !m_req_ff.write) state_ff <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if (m_rsp.done) begin
            hold_ff <= m_rsp;
            if (ull && tick_s) begin
              s_rsp_ff <= m_rsp;
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          if (tick_s) begin
            s_rsp_ff <= hold_ff;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // master side: drain posted writes first so a read never overtakes them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m_req_ff <= '0;
    end else if (m_req_ff.valid) begin
      if (m_rsp.done) m_req_ff <= '0;
    end else if (tick_m && cnt_ff != '0) begin
      m_req_ff <= fifo_ff[rptr_ff];
    end else if (tick_m && state_ff == ST_RISSUE) begin
      m_req_ff <= s_req;
    end
  end

  assign s_rsp = s_rsp_ff;
  assign m_req = m_req_ff;
  assign level = cnt_ff;

endmodule

// *** rtl/dbm_fabric.sv ***
/*
  Dual crossbar fabric: high-speed and low-power crossbars, both bridges,
  low-power tick divider and the register bus slave.
  Assumes masters hold a request until a one-cycle done, slaves answer with a
  one-cycle done, and the register bus follows APB with no byte strobes.
*/
// Decided for this implementation: the APB register port.
module dbm_fabric (
  input  logic                     clk,
  input  logic                     sys_rst,
  input  logic                     psel,
  input  logic                     penable,
  input  logic                     pwrite,
  input  logic [31:0]              paddr,
  input  logic [31:0]              pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  dbm_pkg::dbm_req_t        hs_mst_req [2],
  output dbm_pkg::dbm_rsp_t        hs_mst_rsp [2],
  input  dbm_pkg::dbm_req_t        dma_req,
  output dbm_pkg::dbm_rsp_t        dma_rsp,
  output dbm_pkg::dbm_req_t        hs_slv_req [dbm_pkg::HS_EXT_SLV],
  input  dbm_pkg::dbm_rsp_t        hs_slv_rsp [dbm_pkg::HS_EXT_SLV],
  output dbm_pkg::dbm_req_t        lp_slv_req [dbm_pkg::NUM_SLV],
  input  dbm_pkg::dbm_rsp_t        lp_slv_rsp [dbm_pkg::NUM_SLV]
);

  localparam int NX = dbm_pkg::NUM_XB;
  localparam int NM = dbm_pkg::NUM_MST;
  localparam int NS = dbm_pkg::NUM_SLV;

  dbm_pkg::dbm_req_t             mreq     [NX][NM];
  dbm_pkg::dbm_rsp_t             srsp     [NX][NS];
  dbm_pkg::dbm_req_t             sreq_ff  [NX][NS];
  logic [dbm_pkg::MID_W-1:0]     own_ff   [NX][NS];
  dbm_pkg::dbm_rsp_t             mrsp_ff  [NX][NM];
  logic [NM-1:0]                 want     [NX][NS];
  logic [NM-1:0]                 bad      [NX];
  dbm_pkg::dbm_req_t             down_mreq;
  dbm_pkg::dbm_rsp_t             down_srsp;
  dbm_pkg::dbm_req_t             up_mreq;
  dbm_pkg::dbm_rsp_t             up_srsp;
  logic [dbm_pkg::LVL_W-1:0]     down_lvl;
  logic [dbm_pkg::LVL_W-1:0]     up_lvl;
  logic                          ull_ff;
  logic [dbm_pkg::DIV_W-1:0]     div_ff;
  logic [dbm_pkg::DIV_W-1:0]     div_cnt_ff;
  logic                          lp_tick;
  logic [31:0]                   prdata_ff;
  logic                          pready_ff;
  logic                          pslverr_ff;
  logic                          hit_ull;
  logic                          hit_div;
  logic                          hit_stat;
  logic                          acc;
  logic [31:0]                   stat;

  // populated slave ids per crossbar
  function automatic logic slv_mapped(input int x, input logic [dbm_pkg::SID_W-1:0] s);
    logic [15:0] map;
    map = (x == dbm_pkg::XB_HS) ? dbm_pkg::HS_SLV_MAP : dbm_pkg::LP_SLV_MAP;
    return map[s];
  endfunction

  // lowest requesting master id wins
  function automatic logic [dbm_pkg::MID_W-1:0] lowest(input logic [NM-1:0] w);
    logic [dbm_pkg::MID_W-1:0] r;
    r = '0;
    for (int i = NM - 1; i >= 0; i--) begin
      if (w[i]) r = dbm_pkg::MID_W'(i);
    end
    return r;
  endfunction

  assign mreq[dbm_pkg::XB_HS][dbm_pkg::HS_MID_CORE]   = hs_mst_req[0];
  assign mreq[dbm_pkg::XB_HS][dbm_pkg::HS_MID_DEBUG]  = hs_mst_req[1];
  assign mreq[dbm_pkg::XB_HS][dbm_pkg::HS_MID_UPWARD] = up_mreq;
  assign mreq[dbm_pkg::XB_LP][dbm_pkg::LP_MID_DOWNWARD] = down_mreq;
  assign mreq[dbm_pkg::XB_LP][1]                        = '0;
  assign mreq[dbm_pkg::XB_LP][dbm_pkg::LP_MID_DMA]      = dma_req;

  // slave answers and outbound requests per slot
  for (genvar s = 0; s < NS; s++) begin : g_slot
    if (s < dbm_pkg::HS_EXT_SLV) begin : g_hs_ext
      assign srsp[dbm_pkg::XB_HS][s] = hs_slv_rsp[s];
      assign hs_slv_req[s]           = sreq_ff[dbm_pkg::XB_HS][s];
    end else if (s == dbm_pkg::HS_SID_DOWNWARD) begin : g_hs_down
      assign srsp[dbm_pkg::XB_HS][s] = down_srsp;
    end else begin : g_hs_none
      assign srsp[dbm_pkg::XB_HS][s] = '0;
    end
    if (s == dbm_pkg::LP_SID_UPWARD) begin : g_lp_up
      assign srsp[dbm_pkg::XB_LP][s] = up_srsp;
      assign lp_slv_req[s]           = '0;
    end else begin : g_lp_ext
      assign srsp[dbm_pkg::XB_LP][s] = lp_slv_rsp[s];
      assign lp_slv_req[s]           = sreq_ff[dbm_pkg::XB_LP][s];
    end
  end

  // request matching; a master whose done shows this cycle is masked,
  // since its request line still carries the transfer that just finished
  always_comb begin
    for (int x = 0; x < NX; x++) begin
      bad[x] = '0;
      for (int m = 0; m < NM; m++) begin
        bad[x][m] = mreq[x][m].valid && !mrsp_ff[x][m].done
                    && !slv_mapped(x, mreq[x][m].slave);
      end
      for (int s = 0; s < NS; s++) begin
        want[x][s] = '0;
        for (int m = 0; m < NM; m++) begin
          want[x][s][m] = mreq[x][m].valid && !mrsp_ff[x][m].done
                          && (mreq[x][m].slave == dbm_pkg::SID_W'(s))
                          && slv_mapped(x, dbm_pkg::SID_W'(s));
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int x = 0; x < NX; x++) begin
      for (int s = 0; s < NS; s++) begin
        if (sys_rst) begin
          sreq_ff[x][s] <= '0;
          own_ff[x][s]  <= '0;
        end else if (sreq_ff[x][s].valid) begin
          if (srsp[x][s].done) sreq_ff[x][s] <= '0;
        end else if (want[x][s] != '0) begin
          own_ff[x][s]  <= lowest(want[x][s]);
          sreq_ff[x][s] <= mreq[x][lowest(want[x][s])];
        end
      end
    end
  end

  // answers routed back to the owning master; unmapped ids end in error
  always_ff @(posedge clk) begin
    for (int x = 0; x < NX; x++) begin
      for (int m = 0; m < NM; m++) begin
        if (sys_rst) begin
          mrsp_ff[x][m] <= '0;
        end else begin
          mrsp_ff[x][m] <= '0;
          for (int s = 0; s < NS; s++) begin
            if (sreq_ff[x][s].valid && own_ff[x][s] == dbm_pkg::MID_W'(m)
                && srsp[x][s].done) begin
              mrsp_ff[x][m] <= srsp[x][s];
            end
          end
          if (bad[x][m]) begin
            mrsp_ff[x][m].done <= 1'b1;
            mrsp_ff[x][m].err  <= 1'b1;
          end
        end
      end
    end
  end

  assign hs_mst_rsp[0] = mrsp_ff[dbm_pkg::XB_HS][dbm_pkg::HS_MID_CORE];
  assign hs_mst_rsp[1] = mrsp_ff[dbm_pkg::XB_HS][dbm_pkg::HS_MID_DEBUG];
  assign dma_rsp       = mrsp_ff[dbm_pkg::XB_LP][dbm_pkg::LP_MID_DMA];

  // low-power tick divider
  // a ratio of zero ticks every cycle, which is the undivided case
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_ff <= '0;
    end else if (lp_tick) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end
  assign lp_tick = (div_cnt_ff >= div_ff);

  dbm_bridge #(
    .FIFO_DEPTH   (dbm_pkg::DOWN_FIFO_DEPTH),
    .LP_ON_MASTER (1'b1)
  ) u_downward_bridge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ull     (ull_ff),
    .lp_tick (lp_tick),
    .s_req   (sreq_ff[dbm_pkg::XB_HS][dbm_pkg::HS_SID_DOWNWARD]),
    .s_rsp   (down_srsp),
    .m_req   (down_mreq),
    .m_rsp   (mrsp_ff[dbm_pkg::XB_LP][dbm_pkg::LP_MID_DOWNWARD]),
    .level   (down_lvl)
  );

  dbm_bridge #(
    .FIFO_DEPTH   (dbm_pkg::UP_FIFO_DEPTH),
    .LP_ON_MASTER (1'b0)
  ) u_upward_bridge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ull     (ull_ff),
    .lp_tick (lp_tick),
    .s_req   (sreq_ff[dbm_pkg::XB_LP][dbm_pkg::LP_SID_UPWARD]),
    .s_rsp   (up_srsp),
    .m_req   (up_mreq),
    .m_rsp   (mrsp_ff[dbm_pkg::XB_HS][dbm_pkg::HS_MID_UPWARD]),
    .level   (up_lvl)
  );

  // register decode
  assign hit_ull  = (paddr == dbm_pkg::ULL_CTRL_ADDR);
  assign hit_div  = (paddr == dbm_pkg::LP_DIV_ADDR);
  assign hit_stat = (paddr == dbm_pkg::STATUS_ADDR);
  assign acc      = psel && penable && pready_ff;

  // status word: buffer fill levels and current mode
  always_comb begin
    stat = '0;
    stat[dbm_pkg::STAT_DOWN_LSB +: dbm_pkg::LVL_W] = down_lvl;
    stat[dbm_pkg::STAT_UP_LSB +: dbm_pkg::LVL_W]   = up_lvl;
    stat[dbm_pkg::STAT_ULL_BIT]                    = ull_ff;
  end

  // zero-wait slave: ready and answer prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable
                    && !(hit_ull || hit_div || (hit_stat && !pwrite));
      prdata_ff  <= '0;
      if (psel && !penable && !pwrite) begin
        if (hit_div) prdata_ff <= 32'(div_ff);
        if (hit_stat) prdata_ff <= stat;
      end
    end
  end

  // software-written controls; the mode word is write-only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ull_ff <= dbm_pkg::ULL_RST;
      div_ff <= dbm_pkg::LP_DIV_RST;
    end else if (acc && pwrite) begin
      if (hit_ull) ull_ff <= (pwdata == dbm_pkg::ULL_ENABLE);
      if (hit_div) div_ff <= pwdata[dbm_pkg::DIV_W-1:0];
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// *** bench/dbm_fabric_assertions.sv ***
/*
  Checker for the fabric register bus and master ports.
  Assumes it is bound to dbm_fabric and sees only that module's ports.
*/
module dbm_fabric_chk (
  input logic              clk,
  input logic              sys_rst,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [31:0]       paddr,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input dbm_pkg::dbm_req_t hs_mst_req [2],
  input dbm_pkg::dbm_rsp_t hs_mst_rsp [2],
  input dbm_pkg::dbm_req_t dma_req,
  input dbm_pkg::dbm_rsp_t dma_rsp,
  input dbm_pkg::dbm_req_t hs_slv_req [dbm_pkg::HS_EXT_SLV]
);
  logic lp_bad;
  logic want2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // helper terms: unmapped low-power ids, and requests aimed at slave 2
  assign lp_bad = dma_req.slave == 4'h4 || dma_req.slave == 4'h6 || dma_req.slave > 4'h9;
  assign want2 = (hs_mst_req[0].valid && hs_mst_req[0].slave == 4'h2)
               || (hs_mst_req[1].valid && hs_mst_req[1].slave == 4'h2);

  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_apb_one_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("slave error outside access");
  a_ull_reads_zero: assert property (pready && !pwrite
    && paddr == dbm_pkg::ULL_CTRL_ADDR |-> prdata == '0 && !pslverr)
    else $error("mode word read not zero");
  a_status_wr_refused: assert property (pready && pwrite
    && paddr == dbm_pkg::STATUS_ADDR |-> pslverr)
    else $error("status write accepted");
  a_hs_bad_slave: assert property (hs_mst_req[0].valid && !hs_mst_rsp[0].done
    && hs_mst_req[0].slave > 4'h4 |=> hs_mst_rsp[0].done && hs_mst_rsp[0].err)
    else $error("unmapped fast slave not refused");
  a_lp_bad_slave: assert property (dma_req.valid && !dma_rsp.done && lp_bad
    |=> dma_rsp.done && dma_rsp.err)
    else $error("unmapped low-power slave not refused");
  a_debug_done_pulse: assert property (hs_mst_rsp[1].done |=> !hs_mst_rsp[1].done)
    else $error("debug done longer than one cycle");
  a_dma_done_pulse: assert property (dma_rsp.done |=> !dma_rsp.done)
    else $error("dma done longer than one cycle");
  a_route_slave_two: assert property ($rose(hs_slv_req[2].valid) |-> $past(want2))
    else $error("slave 2 request without a master asking");

  c_concurrent: cover property (hs_mst_rsp[0].done && hs_mst_rsp[1].done);
  c_apb_refused: cover property (pslverr);
  c_dma_refused: cover property (dma_rsp.done && dma_rsp.err);
endmodule

bind dbm_fabric dbm_fabric_chk u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .hs_mst_req, .hs_mst_rsp, .dma_req, .dma_rsp, .hs_slv_req);

// *** bench/dbm_slv_model.sv ***
/*
  Slave partner: one word of storage per slot, one done pulse per request.
  Assumes requests hold until done and drop in the cycle after it.
*/
module dbm_slv_model #(
  parameter int N = 4
) (
  input  logic              clk,
  input  logic              sys_rst,
  input  logic [3:0]        wait_cyc,
  input  dbm_pkg::dbm_req_t req [N],
  output dbm_pkg::dbm_rsp_t rsp [N]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_ff [N];
  logic [3:0]  cnt_ff [N];
  logic        ans_ff [N];

  // answer once after wait_cyc extra cycles; a request still up at the edge
  // after done is not served twice; idle read data toggles so it is never stale
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      rsp[i].done <= 1'b0;
      rsp[i].err <= 1'b0;
      rsp[i].rdata <= ~rsp[i].rdata;
      if (sys_rst) begin
        ans_ff[i] <= 1'b0;
        cnt_ff[i] <= '0;
        mem_ff[i] <= '0;
        rsp[i].rdata <= '0;
      end else if (!req[i].valid) begin
        ans_ff[i] <= 1'b0;
        cnt_ff[i] <= '0;
      end else if (!ans_ff[i] && cnt_ff[i] == wait_cyc) begin
        rsp[i].done <= 1'b1;
        rsp[i].rdata <= mem_ff[i];
        ans_ff[i] <= 1'b1;
        if (req[i].write) mem_ff[i] <= req[i].wdata;
      end else if (!ans_ff[i]) begin
        cnt_ff[i] <= cnt_ff[i] + 4'h1;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
/*
  Testbench: register bus and master-port tasks, directed tests of the fabric.
  Assumes the slave partner answers the fast side at once, the slow side late.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = 4;
  logic              clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0]       paddr, pwdata, prdata, rd;
  dbm_pkg::dbm_req_t hs_mst_req [2];
  dbm_pkg::dbm_rsp_t hs_mst_rsp [2];
  dbm_pkg::dbm_req_t dma_req, hs_slv_req [dbm_pkg::HS_EXT_SLV], lp_slv_req [10];
  dbm_pkg::dbm_rsp_t dma_rsp, hs_slv_rsp [dbm_pkg::HS_EXT_SLV], lp_slv_rsp [10];
  int                num_errors, samples_checked, cycles, n0, n1, nw [4];
  logic [3:0]        lp_ok [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9};

  dbm_fabric dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hs_mst_req, .hs_mst_rsp, .dma_req, .dma_rsp, .hs_slv_req,
    .hs_slv_rsp, .lp_slv_req, .lp_slv_rsp);
  dbm_slv_model #(.N(4)) u_hs (.clk, .sys_rst, .wait_cyc(4'h0), .req(hs_slv_req),
    .rsp(hs_slv_rsp));
  dbm_slv_model #(.N(10)) u_lp (.clk, .sys_rst, .wait_cyc(4'h2), .req(lp_slv_req),
    .rsp(lp_slv_rsp));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one register bus transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [31:0] a, d, x, input logic xe);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no own limit here: a missing ready is left to the bench timeout
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    check({pslverr, wr ? x : prdata}, {xe, x});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // one master transfer on port p (2 is the dma port); n counts edges to done
  task automatic xfer(input int p, input logic wr, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] r, output logic e, output int n);
    dbm_pkg::dbm_req_t q;
    dbm_pkg::dbm_rsp_t a;
    q = '{valid: 1'b1, write: wr, slave: s, addr: {26'h0, s, 2'h0}, wdata: d};
    for (int k = 0; k < 2; k++) begin
      case (p)
        0: hs_mst_req[0] <= q;
        1: hs_mst_req[1] <= q;
        default: dma_req <= q;
      endcase
      n = (k == 0) ? 0 : n;
      do begin
        @(posedge clk);
        n++;
        a = (p == 2) ? dma_rsp : hs_mst_rsp[p % 2];
      end while (k == 0 && a.done !== 1'b1 && n < 5000);
      r = (k == 0) ? a.rdata : r;
      e = (k == 0) ? a.err : e;
      q = '0;
    end
    n--;
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, dma_req} = '0;
    hs_mst_req = '{default: '0};
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, dbm_pkg::STATUS_ADDR, '0, '0, 1'b0);
    apb(1'b0, dbm_pkg::LP_DIV_ADDR, '0, '0, 1'b0);
    apb(1'b1, dbm_pkg::STATUS_ADDR, 32'h0000_0005, '0, 1'b1);
    apb(1'b1, 32'h4100_8200, '0, '0, 1'b1);
    apb(1'b1, dbm_pkg::ULL_CTRL_ADDR, 32'h0000_0002, '0, 1'b0);
    apb(1'b0, dbm_pkg::STATUS_ADDR, '0, '0, 1'b0);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      xfer(s % 2, 1'b1, 4'(s), 32'hA5A5_0F00 + s, rd, er, n0);
      check(33'(n0), LAT);
      xfer(s % 2, 1'b0, 4'(s), '0, rd, er, n0);
      check({er, rd}, {1'b0, 32'hA5A5_0F00 + s});
    end
    // core port, so the unmapped-slave assertion on that port is reached
    xfer(0, 1'b0, 4'h5, '0, rd, er, n0);
    check(33'(er), 33'h1);
    fork
      xfer(0, 1'b1, 4'h0, 32'h1234_5678, rd, er, n0);
      xfer(1, 1'b1, 4'h1, 32'h8765_4321, rd, er, n1);
    join
    check({1'(n0 == LAT), 32'(n1)}, {1'b1, 32'(LAT)});
    fork
      xfer(0, 1'b0, 4'h2, '0, rd, er, n0);
      xfer(1, 1'b0, 4'h2, '0, rd, er, n1);
    join
    check({1'(n0 == LAT), 32'(n1 > LAT)}, 33'h1_0000_0001);
    $display("test fast crossbar done");
    foreach (lp_ok[i]) begin
      xfer(2, 1'b1, lp_ok[i], 32'h5A5A_0000 + i, rd, er, n0);
      xfer(2, 1'b0, lp_ok[i], '0, rd, er, n0);
      check({er, rd}, {1'b0, 32'h5A5A_0000 + i});
    end
    xfer(2, 1'b0, 4'h6, '0, rd, er, n0);
    check(33'(er), 33'h1);
    xfer(2, 1'b1, 4'h8, 32'hC3C3_0001, rd, er, n0);
    check(33'(er), 33'h0);
    $display("test low-power crossbar done");
    xfer(0, 1'b0, 4'h4, '0, rd, er, n0);
    apb(1'b1, dbm_pkg::ULL_CTRL_ADDR, dbm_pkg::ULL_ENABLE, '0, 1'b0);
    apb(1'b0, dbm_pkg::STATUS_ADDR, '0, 32'h0000_0100, 1'b0);
    xfer(0, 1'b0, 4'h4, '0, rd, er, n1);
    check(33'(n0 - n1), 33'(dbm_pkg::RD_STALL) + 33'h1);
    apb(1'b1, dbm_pkg::ULL_CTRL_ADDR, '0, '0, 1'b0);
    // ratio three: the read's launch falls between low-power edges and must wait
    apb(1'b1, dbm_pkg::LP_DIV_ADDR, 32'h0000_0003, '0, 1'b0);
    xfer(0, 1'b0, 4'h4, '0, rd, er, n1);
    check(33'(n1 > n0), 33'h1);
    apb(1'b1, dbm_pkg::LP_DIV_ADDR, 32'h0000_00FF, '0, 1'b0);
    for (int k = 0; k < 4; k++) xfer(0, 1'b1, 4'h4, 32'h0BAD_0000 + k, rd, er, nw[k]);
    check({1'(nw[1] == nw[0]), 32'(nw[2] == nw[0])}, 33'h1_0000_0001);
    check(33'(nw[3] > nw[0]), 33'h1);
    apb(1'b1, dbm_pkg::LP_DIV_ADDR, '0, '0, 1'b0);
    $display("test bridges done");
    tally_and_finish();
  end
endmodule
